// file: rtl/sfr_regs.svh
// register offsets, fields, reset values and register width for the synth ratio block
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH
`define SFR_IDX_A_FRAC_LOW   3'h0
`define SFR_IDX_A_FRAC_MID   3'h1
`define SFR_IDX_A_DIV_HIGH   3'h2
`define SFR_IDX_A_SCALING    3'h3
`define SFR_IDX_B_FRAC_LOW   3'h4
`define SFR_IDX_B_FRAC_MID   3'h5
`define SFR_IDX_READBACK     3'h6
`define SFR_RST_A_FRAC_LOW   9'h121
`define SFR_RST_A_FRAC_MID   9'h17E
`define SFR_RST_A_DIV_HIGH   9'h07D
`define SFR_RST_A_SCALING    9'h014
`define SFR_RST_B_FRAC_LOW   9'h121
`define SFR_RST_B_FRAC_MID   9'h17E
`define SFR_RST_READBACK     9'h000
`define SFR_BIT_PRESCALE     0
`define SFR_BIT_POSTSCALE    1
`define SFR_BIT_FRAC_ENABLE  2
`define SFR_BIT_CONT_READ    0
`define SFR_REG_WIDTH        9
`endif

// file: rtl/sfr_pkg.sv
// types for the synth ratio configuration block
package sfr_pkg;
  typedef enum logic [1:0] {
    SFR_RANGE_192K = 2'b00,
    SFR_RANGE_96K  = 2'b01,
    SFR_RANGE_48K  = 2'b10,
    SFR_RANGE_32K  = 2'b11
  } sfr_range_t;
  typedef enum logic [0:0] {
    SFR_PH_IDLE = 1'b0,
    SFR_PH_DATA = 1'b1
  } sfr_phase_t;
endpackage : sfr_pkg

// file: rtl/sfr_halver.sv
// optional divide-by-two stage, realised as an enable-rate toggle
`timescale 1ns/100ps
module sfr_halver (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic clk_en,
  // stream
  input  wire logic halve,
  input  wire logic tick_in,
  output logic      tick_out
);
  logic phase_reg;
  logic phase_next;
  assign phase_next = (tick_in && halve) ? ~phase_reg : phase_reg;
  // with halve low every tick passes; with halve high every second one
  assign tick_out = tick_in && (!halve || phase_reg);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= 1'b0;
    end else if (clk_en) begin
      phase_reg <= phase_next;
    end
  end
endmodule : sfr_halver

// file: rtl/sfr_ratio_regs.sv
// ahb-lite register block for the two synth ratio settings
`timescale 1ns/100ps
`include "sfr_regs.svh"
module sfr_ratio_regs #(
  parameter logic [8:0] IDENTITY_LOW    = 9'h0A5, // arbitrary value
  parameter logic [8:0] IDENTITY_HIGH   = 9'h05A, // arbitrary value
  parameter logic [8:0] REVISION_NUMBER = 9'h003  // arbitrary value
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // master clock pin
  input  wire logic        mclk_pin,
  // synth a settings
  output logic [21:0]      synth_a_fraction,
  output logic [3:0]       synth_a_integer_divisor,
  output logic             synth_a_fraction_enable,
  output logic [1:0]       synth_a_range_select,
  output logic             synth_a_range_valid,
  output logic             synth_a_ref_tick,
  output logic             synth_a_output_clock,
  // synth a output edge from the synthesiser
  input  wire logic        synth_a_raw_tick,
  // synth b settings
  output logic [21:0]      synth_b_fraction,
  // transmit source select from the s/pdif block
  input  wire logic [1:0]  spdif_tx_source_select
);
  sfr_pkg::sfr_phase_t phase_reg;
  logic [2:0]  idx_reg;
  logic        wr_reg;
  logic [8:0]  a_low_reg;
  logic [8:0]  a_mid_reg;
  logic [8:0]  a_high_reg;
  logic [8:0]  a_scale_reg;
  logic [8:0]  b_low_reg;
  logic [8:0]  b_mid_reg;
  logic [8:0]  b_high_reg;
  logic [8:0]  rdbk_reg;
  logic [31:0] hrdata_reg;
  logic        mclk_s1_reg;
  logic        mclk_s2_reg;
  logic        mclk_s3_reg;
  logic        post_reg;
  wire         addr_take;
  wire         addr_ok;
  wire         wr_go;
  wire         rd_go;
  wire  [2:0]  addr_idx;
  wire  [8:0]  wdat;
  wire  [8:0]  rd_mux;
  wire  [8:0]  rd_low;
  wire  [8:0]  rd_mid;
  wire  [8:0]  a_low_next;
  wire  [8:0]  a_mid_next;
  wire  [8:0]  a_high_next;
  wire  [8:0]  a_scale_next;
  wire  [8:0]  b_low_next;
  wire  [8:0]  b_mid_next;
  wire  [8:0]  rdbk_next;
  wire         mclk_rise;
  wire         post_tick;
  wire         cont_read;

  function automatic logic sel(input logic [2:0] a, input logic [2:0] b);
    sel = (a == b);
  endfunction : sel

  assign addr_take = hsel && hready && htrans[1] && clk_en;
  assign addr_idx  = haddr[4:2];
  // only word accesses inside the map reach the registers; others read zero
  assign addr_ok   = (haddr[31:5] == 27'h0000000) && (haddr[1:0] == 2'b00)
                     && (hsize == 3'b010) && (addr_idx <= `SFR_IDX_READBACK);
  assign wr_go     = (phase_reg == sfr_pkg::SFR_PH_DATA) && wr_reg && clk_en;
  assign rd_go     = addr_take && !hwrite && addr_ok;
  // unused bits dropped on write, so stray ones never reach the synth
  assign wdat      = hwdata[8:0];
  // next values feed the read mux too, so a read right after a write sees it
  assign a_low_next   = (wr_go && sel(idx_reg, `SFR_IDX_A_FRAC_LOW)) ? wdat : a_low_reg;
  assign a_mid_next   = (wr_go && sel(idx_reg, `SFR_IDX_A_FRAC_MID)) ? wdat : a_mid_reg;
  assign a_high_next  = (wr_go && sel(idx_reg, `SFR_IDX_A_DIV_HIGH)) ? {1'b0, wdat[7:0]}
                                                                     : a_high_reg;
  assign a_scale_next = (wr_go && sel(idx_reg, `SFR_IDX_A_SCALING)) ? {4'h0, wdat[4:0]}
                                                                    : a_scale_reg;
  assign b_low_next   = (wr_go && sel(idx_reg, `SFR_IDX_B_FRAC_LOW)) ? wdat : b_low_reg;
  assign b_mid_next   = (wr_go && sel(idx_reg, `SFR_IDX_B_FRAC_MID)) ? wdat : b_mid_reg;
  assign rdbk_next    = (wr_go && sel(idx_reg, `SFR_IDX_READBACK)) ? {8'h00, wdat[0]}
                                                                   : rdbk_reg;
  assign cont_read = rdbk_next[`SFR_BIT_CONT_READ];

  // identity masks the stored bits unless continuous readback is on
  assign rd_low = cont_read ? a_low_next : IDENTITY_LOW;
  assign rd_mid = cont_read ? a_mid_next : IDENTITY_HIGH;

  // read mux: identity and revision mask stored bits, which stay untouched
  assign rd_mux =
    sel(addr_idx, `SFR_IDX_A_FRAC_LOW) ? rd_low :
    sel(addr_idx, `SFR_IDX_A_FRAC_MID) ? rd_mid :
    sel(addr_idx, `SFR_IDX_A_DIV_HIGH) ? REVISION_NUMBER :
    sel(addr_idx, `SFR_IDX_A_SCALING)  ? {4'h0, a_scale_next[4:0]} :
    sel(addr_idx, `SFR_IDX_B_FRAC_LOW) ? b_low_next :
    sel(addr_idx, `SFR_IDX_B_FRAC_MID) ? b_mid_next :
    {8'h00, rdbk_next[0]};

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= sfr_pkg::SFR_PH_IDLE;
      idx_reg   <= 3'h0;
      wr_reg    <= 1'b0;
    end else if (clk_en && hready) begin
      phase_reg <= addr_take ? sfr_pkg::SFR_PH_DATA : sfr_pkg::SFR_PH_IDLE;
      idx_reg   <= addr_idx;
      wr_reg    <= addr_take && hwrite && addr_ok;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h00000000;
    end else if (clk_en && addr_take) begin
      hrdata_reg <= rd_go ? {23'h000000, rd_mux} : 32'h00000000;
    end
  end

  // writes always land in storage, identity masking is read-side only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_low_reg   <= `SFR_RST_A_FRAC_LOW;
      a_mid_reg   <= `SFR_RST_A_FRAC_MID;
      a_high_reg  <= `SFR_RST_A_DIV_HIGH;
      a_scale_reg <= `SFR_RST_A_SCALING;
      b_low_reg   <= `SFR_RST_B_FRAC_LOW;
      b_mid_reg   <= `SFR_RST_B_FRAC_MID;
      rdbk_reg    <= `SFR_RST_READBACK;
    end else begin
      a_low_reg   <= a_low_next;
      a_mid_reg   <= a_mid_next;
      a_high_reg  <= a_high_next;
      a_scale_reg <= a_scale_next;
      b_low_reg   <= b_low_next;
      b_mid_reg   <= b_mid_next;
      rdbk_reg    <= rdbk_next;
    end
  end

  // synth b top bits have no register here; held at their reset value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      b_high_reg <= `SFR_RST_A_DIV_HIGH;
    end else begin
      b_high_reg <= b_high_reg;
    end
  end

  // divisor range 6..12 is advisory; any code is passed through
  assign synth_a_integer_divisor = a_high_reg[7:4];
  assign synth_a_fraction = {a_high_reg[3:0], a_mid_reg, a_low_reg};
  assign synth_a_fraction_enable = a_scale_reg[`SFR_BIT_FRAC_ENABLE];
  assign synth_a_range_select = a_scale_reg[4:3];
  assign synth_a_range_valid = (spdif_tx_source_select != 2'b00);
  assign synth_b_fraction = {b_high_reg[3:0], b_mid_reg, b_low_reg};

  // pin sampled twice before use; edge detect reads only later stages
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mclk_s1_reg <= 1'b0;
      mclk_s2_reg <= 1'b0;
      mclk_s3_reg <= 1'b0;
    end else if (clk_en) begin
      mclk_s1_reg <= mclk_pin;
      mclk_s2_reg <= mclk_s1_reg;
      mclk_s3_reg <= mclk_s2_reg;
    end
  end
  assign mclk_rise = mclk_s2_reg && !mclk_s3_reg;

  // pin rate must stay below hclk/2 for edges to be seen
  sfr_halver u_pre (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .clk_en   (clk_en),
    .halve    (a_scale_reg[`SFR_BIT_PRESCALE]),
    .tick_in  (mclk_rise),
    .tick_out (synth_a_ref_tick)
  );

  sfr_halver u_post (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .clk_en   (clk_en),
    .halve    (a_scale_reg[`SFR_BIT_POSTSCALE]),
    .tick_in  (synth_a_raw_tick),
    .tick_out (post_tick)
  );

  // output clock toggles on each surviving tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      post_reg <= 1'b0;
    end else if (clk_en && post_tick) begin
      post_reg <= ~post_reg;
    end
  end
  assign synth_a_output_clock = post_reg;
endmodule : sfr_ratio_regs

// file: testbench/sfr_ratio_regs_props.sv
// port-level checks for the synth ratio register block
`timescale 1ns/100ps
module sfr_ratio_regs_props #(
  parameter logic [8:0] IDENTITY_LOW    = 9'h0A5,
  parameter logic [8:0] IDENTITY_HIGH   = 9'h05A,
  parameter logic [8:0] REVISION_NUMBER = 9'h003
) (
  // bus side, several to a line to keep the checker short
  input wire logic        hclk, hresetn, clk_en, hsel, hwrite, hready, hreadyout,
  input wire logic [31:0] haddr, hwdata, hrdata,
  input wire logic [1:0]  htrans, spdif_tx_source_select, synth_a_range_select,
  input wire logic [2:0]  hsize,
  // synth settings
  input wire logic [21:0] synth_a_fraction, synth_b_fraction,
  input wire logic [3:0]  synth_a_integer_divisor,
  input wire logic        synth_a_fraction_enable, synth_a_range_valid
);
  logic       wr_q;
  logic       rd_q;
  logic       cr_q;
  logic [2:0] ix_q;
  wire        tk = hsel & hready & htrans[1] & clk_en & (hsize == 3'h2) & (haddr[1:0] == 2'h0);
  wire        dw = clk_en & wr_q;
  // mirror of the data phase so answers can be tied to their address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      ix_q <= 3'h0;
    end else if (clk_en) begin
      wr_q <= tk & hwrite & (haddr[31:5] == 27'h0);
      rd_q <= tk & !hwrite & (haddr[31:5] == 27'h0);
      ix_q <= haddr[4:2];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cr_q <= 1'b0;
    else if (dw && ix_q == 3'h6) cr_q <= hwdata[0];
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_frac_low: assert property (dw && ix_q == 3'h0
    |=> synth_a_fraction[8:0] == $past(hwdata[8:0])) else $error("fraction low not loaded");
  chk_frac_top: assert property (dw && ix_q == 3'h2
    |=> synth_a_fraction[21:18] == $past(hwdata[3:0])) else $error("fraction top not loaded");
  chk_divisor_load: assert property (dw && ix_q == 3'h2
    |=> synth_a_integer_divisor == $past(hwdata[7:4])) else $error("divisor not loaded");
  chk_identity_read: assert property (rd_q && !cr_q && ix_q < 3'h2
    |-> hrdata == {23'h0, ix_q[0] ? IDENTITY_HIGH : IDENTITY_LOW}) else $error("identity wrong");
  chk_continuous_readback_data: assert property (rd_q && cr_q && ix_q == 3'h0
    |-> hrdata[8:0] == synth_a_fraction[8:0]) else $error("stored bits not returned");
  chk_revision_read: assert property (rd_q && ix_q == 3'h2
    |-> hrdata == {23'h0, REVISION_NUMBER}) else $error("revision wrong");
  chk_mode_fields: assert property (dw && ix_q == 3'h3
    |=> synth_a_fraction_enable == $past(hwdata[2]) && synth_a_range_select == $past(hwdata[4:3]))
    else $error("mode fields not loaded");
  chk_range_valid: assert property (synth_a_range_valid == (spdif_tx_source_select != 2'h0))
    else $error("range valid wrong");
  chk_frac_b_mid: assert property (dw && ix_q == 3'h5
    |=> synth_b_fraction[17:9] == $past(hwdata[8:0])) else $error("synth b mid not loaded");
  chk_read_steady: assert property (rd_q |=> $stable(synth_a_fraction))
    else $error("read disturbed ratio");
  chk_zero_wait: assert property (hreadyout) else $error("wait state inserted");
  cover property (rd_q && cr_q && ix_q == 3'h0);
  cover property (dw && ix_q == 3'h3);
  cover property (rd_q && ix_q == 3'h2);
endmodule : sfr_ratio_regs_props
bind sfr_ratio_regs sfr_ratio_regs_props #(.IDENTITY_LOW(IDENTITY_LOW),
  .IDENTITY_HIGH(IDENTITY_HIGH), .REVISION_NUMBER(REVISION_NUMBER)) i_sfr_ratio_regs_props (
  .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata),
  .htrans(htrans), .spdif_tx_source_select(spdif_tx_source_select), .hsize(hsize),
  .synth_a_range_select(synth_a_range_select), .synth_a_fraction(synth_a_fraction),
  .synth_b_fraction(synth_b_fraction), .synth_a_integer_divisor(synth_a_integer_divisor),
  .synth_a_fraction_enable(synth_a_fraction_enable), .synth_a_range_valid(synth_a_range_valid));

// file: testbench/sfr_ratio_regs_tb.sv
// self-checking bench for the synth ratio register block
`timescale 1ns/100ps
module sfr_ratio_regs_tb;
  localparam logic [8:0] ID_LO = 9'h0C3; // arbitrary value
  localparam logic [8:0] ID_HI = 9'h03C; // arbitrary value
  localparam logic [8:0] REV   = 9'h005; // arbitrary value
  logic        hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        mclk_pin = 1'b0, raw = 1'b0, hreadyout, hresp, fen, rvalid, rtick, oclk;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, tx_src = 2'h0, rsel;
  logic [2:0]  hsize = 3'h2;
  logic [21:0] fa, fb;
  logic [3:0]  div;
  int          mismatches = 0, n_checks = 0;
  sfr_ratio_regs #(.IDENTITY_LOW(ID_LO), .IDENTITY_HIGH(ID_HI), .REVISION_NUMBER(REV))
  i_sfr_ratio_regs (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .mclk_pin(mclk_pin), .synth_a_fraction(fa), .synth_a_integer_divisor(div),
    .synth_a_fraction_enable(fen), .synth_a_range_select(rsel), .synth_a_range_valid(rvalid),
    .synth_a_ref_tick(rtick), .synth_a_output_clock(oclk), .synth_a_raw_tick(raw),
    .synth_b_fraction(fb), .spdif_tx_source_select(tx_src));
  initial forever #12.5 hclk = ~hclk;
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_rdy;
    for (int k = 0; k < 20; k++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    mismatches++;
    report_and_stop;
  endtask : wait_rdy
  // entered just after a rising edge; request held until hready seen high
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
    wait_rdy;
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask : xfer
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
    check(hresp, 32'h0);
  endtask : rchk
  task automatic t_reset;
    rchk(32'h00, {23'h0, ID_LO});
    rchk(32'h04, {23'h0, ID_HI});
    rchk(32'h0C, 32'h14);
    check(fa, {4'hD, 9'h17E, 9'h121});
    check(div, 32'h7);
  endtask : t_reset
  task automatic t_write;
    xfer(1'b1, 32'h00, 32'h1AB);
    xfer(1'b1, 32'h04, 32'h0CD);
    xfer(1'b1, 32'h08, 32'h0A3);
    rchk(32'h00, {23'h0, ID_LO});
    rchk(32'h08, {23'h0, REV});
    check(fa, {4'h3, 9'h0CD, 9'h1AB});
    check(div, 32'hA);
    xfer(1'b1, 32'h18, 32'h1);
    rchk(32'h00, 32'h1AB);
    rchk(32'h04, 32'h0CD);
    xfer(1'b1, 32'h18, 32'h0);
    rchk(32'h04, {23'h0, ID_HI});
    xfer(1'b1, 32'h1C, 32'h1FF);
    rchk(32'h1C, 32'h0);
    xfer(1'b1, 32'h10, 32'h055);
    xfer(1'b1, 32'h14, 32'h0AA);
    rchk(32'h14, 32'h0AA);
    check(fb, {4'hD, 9'h0AA, 9'h055});
  endtask : t_write
  task automatic t_modes;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 32'h0C, {27'h0, i[1:0], i[0], 2'h0});
      rchk(32'h0C, {27'h0, i[1:0], i[0], 2'h0});
      check(rsel, i[1:0]);
      check(fen, i[0]);
      tx_src <= i[1:0];
      @(posedge hclk);
      check(rvalid, i != 0);
    end
  endtask : t_modes
  // 16 reference rises and 16 synth ticks; an even count hides the halver phase
  task automatic t_halve;
    int nr, no;
    logic po;
    for (int h = 0; h < 2; h++) begin
      xfer(1'b1, 32'h0C, {30'h0, h[0], h[0]});
      nr = 0;
      no = 0;
      po = oclk;
      for (int c = 0; c < 80; c++) begin
        @(posedge hclk);
        mclk_pin <= (c % 4 < 2) && c < 64;
        raw <= (c % 4 == 0) && c < 64;
        nr += rtick;
        no += (oclk !== po);
        po = oclk;
      end
      check(nr, h ? 8 : 16);
      check(no, h ? 8 : 16);
    end
  endtask : t_halve
  // clk_en low must hold every flop, so synth ticks in that time are lost
  task automatic t_freeze;
    logic po;
    po = oclk;
    clk_en <= 1'b0;
    raw    <= 1'b1;
    repeat (4) @(posedge hclk);
    check(oclk, po);
    clk_en <= 1'b1;
    raw    <= 1'b0;
    @(posedge hclk);
  endtask : t_freeze
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_write;
    t_modes;
    t_halve;
    t_freeze;
    report_and_stop;
  end
endmodule : sfr_ratio_regs_tb
